/* sim/hswt_tone_meter.sv */
/*
 * Listener on the shared port pin, standing in for a buzzer or a
 * frequency counter. Assumes the pin is only meaningful while enabled.
 */
`timescale 1ns/1ps
module hswt_tone_meter (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Pin under observation
    input wire logic pin_in,
    input wire logic oe_in,
    // Last full period in clocks and count of rising edges
    output logic [31:0] period_out,
    output logic [31:0] edges_out
);
    logic last_q;
    logic [31:0] cnt_q;
    wire logic rise = oe_in && pin_in && !last_q;

    // A floating pin is ignored: only enabled rising edges count
    always_ff @(posedge mclk_in) begin
        last_q <= pin_in;
        if (sys_rst_in) begin
            cnt_q <= 32'h0;
            period_out <= 32'h0;
            edges_out <= 32'h0;
        end else if (rise) begin
            period_out <= cnt_q;
            cnt_q <= 32'h1;
            edges_out <= edges_out + 32'h1;
        end else begin
            cnt_q <= cnt_q + 32'h1;
        end
    end
endmodule

/* sim/tb.sv */
/*
 * Self-checking bench for the watch timer with a tone listener.
 * Assumes fast feed keeps the tick wait near 156k clocks.
 */
`timescale 1ns/1ps
module tb;
    import hswt_pkg::*;
    typedef struct packed {
        logic [7:0] wd;
        logic pm;
        logic lt;
    } hswt_row_s;
    logic mclk_in = 0, sys_rst_in = 1, mode_wr_in = 0;
    logic div_clear_in = 0, flag_clear_in = 0, standby_in = 0;
    logic port_out_mode_in = 0, port_latch_in = 0;
    logic [7:0] mode_wdata_in = 8'h00;
    logic [7:0] mode_rdata_out;
    logic flag, wake, pin, oe;
    logic [31:0] period, edges;
    int n_errors = 0, checked = 0, cycles = 0, t_clr, k;
    // Bit 0 stays clear in every write
    hswt_row_s rows [5] = '{'{8'h4C, 1'b1, 1'b1}, '{8'h06, 1'b1, 1'b0},
        '{8'h84, 1'b0, 1'b1}, '{8'hB4, 1'b0, 1'b0}, '{8'h24, 1'b1, 1'b1}};
    logic [1:0] sels [3] = '{HSWT_SEL_2K, HSWT_SEL_4K, HSWT_SEL_FW};
    int fq [3] = '{2048, 4096, 32768};

    hswt_watch_timer uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .mode_wr_in(mode_wr_in), .mode_wdata_in(mode_wdata_in),
        .mode_rdata_out(mode_rdata_out), .div_clear_in(div_clear_in),
        .flag_clear_in(flag_clear_in), .standby_in(standby_in),
        .watch_tick_flag_out(flag), .standby_wake_out(wake),
        .port_out_mode_in(port_out_mode_in), .port_latch_in(port_latch_in),
        .port2_bit3_pin_out(pin), .port2_bit3_pin_oe_out(oe));
    hswt_tone_meter meter (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .pin_in(pin), .oe_in(oe), .period_out(period), .edges_out(edges));

    // Clock and hang guard
    initial forever #12.5 mclk_in = ~mclk_in;
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 200000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic sample(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    task automatic write_mode(input logic [7:0] v);
        @(posedge mclk_in);
        mode_wr_in <= 1;
        mode_wdata_in <= v;
        @(posedge mclk_in);
        mode_wr_in <= 0;
    endtask
    // Waits for three rising edges so a partial first period is dropped
    task automatic measure(input int expc);
        logic [31:0] e0;
        int n;
        e0 = edges;
        n = 0;
        while (edges < e0 + 3 && n < 70000) begin
            sample(1);
            n++;
        end
        check((period > expc - 4) && (period < expc + 4), 1);
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        sample(16);
        @(posedge mclk_in);
        sys_rst_in <= 0;
        sample(1);
        check({mode_rdata_out, flag, wake, pin, oe}, 0);
        // Table of mode writes and port settings with the tone silent
        foreach (rows[i]) begin
            @(posedge mclk_in);
            port_out_mode_in <= rows[i].pm;
            port_latch_in <= rows[i].lt;
            write_mode(rows[i].wd);
            sample(3);
            check(mode_rdata_out & 8'hF7, rows[i].wd & HSWT_MODE_RMASK);
            check({oe, pin}, {rows[i].pm, rows[i].lt});
        end
        // Fast feed from a cleared divider, every tone meanwhile
        port_out_mode_in <= 1;
        write_mode(8'h86);
        @(posedge mclk_in);
        div_clear_in <= 1;
        t_clr = cycles;
        @(posedge mclk_in);
        div_clear_in <= 0;
        standby_in <= 1;
        for (int s = 0; s < 3; s++) begin
            write_mode({2'b10, sels[s], 4'b0110});
            measure(int'(HSWT_CLK_HZ / fq[s]));
        end
        k = 0;
        while (flag !== 1'b1 && k < 160000) begin
            sample(1);
            k++;
        end
        k = cycles - t_clr;
        check(k > 155300 && k < 156300, 1);
        sample(1);
        check(wake, 1);
        // Divider clear leaves the flag alone
        @(posedge mclk_in);
        div_clear_in <= 1;
        @(posedge mclk_in);
        div_clear_in <= 0;
        sample(2);
        check(flag, 1);
        @(posedge mclk_in);
        standby_in <= 0;
        sample(2);
        check(wake, 0);
        @(posedge mclk_in);
        standby_in <= 1;
        sample(2);
        check(wake, 1);
        @(posedge mclk_in);
        flag_clear_in <= 1;
        @(posedge mclk_in);
        flag_clear_in <= 0;
        sample(2);
        check({flag, wake}, 0);
        // Second reset in mid-run
        @(posedge mclk_in);
        sys_rst_in <= 1;
        sample(2);
        @(posedge mclk_in);
        sys_rst_in <= 0;
        sample(1);
        check({mode_rdata_out, flag}, 0);
        print_verdict();
    end
endmodule

/* src/hswt_nco.sv */
/*
 * Phase accumulator making one-cycle enable pulses at a fixed rate.
 * Assumes the step is far below half the accumulator range.
 */
`timescale 1ns/1ps
module hswt_nco #(
    parameter int W = hswt_pkg::HSWT_NCO_W,
    parameter logic [W-1:0] STEP = hswt_pkg::HSWT_NCO_STEP
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Control
    input wire logic clear_in,
    // Enable pulse
    output logic pulse_out
);
    import hswt_pkg::*;

    logic [W:0] acc_sum;
    logic [W-1:0] acc_q;
    logic [15:0] gap_q;

    // Carry out of the sum marks one output period
    assign acc_sum = {1'b0, acc_q} + {1'b0, STEP};

    // Clear restarts phase so the chain begins from zero seconds
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in || clear_in) begin
            acc_q <= '0;
            pulse_out <= 1'b0;
        end else begin
            acc_q <= acc_sum[W-1:0];
            pulse_out <= acc_sum[W];
        end
    end

    // Helper for the max-gap check only
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in || clear_in || pulse_out) begin
            gap_q <= 16'h0001;
        end else if (gap_q != 16'hFFFF) begin
            gap_q <= gap_q + 16'h0001;
        end
    end

    property p_nco_gap;
        @(posedge mclk_in) disable iff (sys_rst_in || clear_in)
        (pulse_out && !$past(clear_in) && $past(pulse_out, 1) == 1'b0 &&
         gap_q > 16'h0100) |-> 1'b1;
    endproperty
    property p_nco_spacing;
        @(posedge mclk_in) disable iff (sys_rst_in || clear_in)
        $rose(pulse_out) |=> !pulse_out [*8];
    endproperty
    property p_nco_max_gap;
        @(posedge mclk_in) disable iff (sys_rst_in || clear_in)
        !pulse_out |-> gap_q <= 16'(HSWT_HALF_GAP_MAX);
    endproperty
    a_nco_spacing: assert property (p_nco_spacing)
        else $error("nco pulses too close");
    a_nco_max_gap: assert property (p_nco_max_gap)
        else $error("nco gap too long");
endmodule

/* src/hswt_pkg.sv */
/*
 * Constants and types shared by the half-second watch timer.
 * Assumes a 40 MHz core clock and a mode register written by local logic.
 */
package hswt_pkg;
    // Clock rates and the divider chain
    localparam longint HSWT_CLK_HZ = 40_000_000;
    localparam longint HSWT_FX_NOM_HZ = 4_194_304;
    localparam longint HSWT_FX_PER_FW = 128;
    localparam longint HSWT_FW_HZ = HSWT_FX_NOM_HZ / HSWT_FX_PER_FW;
    localparam longint HSWT_HALF_HZ = 2 * HSWT_FW_HZ;
    localparam int HSWT_NCO_W = 24;
    localparam logic [HSWT_NCO_W-1:0] HSWT_NCO_STEP =
        HSWT_NCO_W'((HSWT_HALF_HZ << HSWT_NCO_W) / HSWT_CLK_HZ);
    localparam int HSWT_HALF_GAP_MIN = 610;
    localparam int HSWT_HALF_GAP_MAX = 611;

    // Half-tick counter: bit 0 is the base clock, tone taps above it
    localparam int HSWT_CNT_W = 16;
    localparam int HSWT_TICK_BITS_NORM = 15;
    localparam int HSWT_TICK_BITS_FAST = 8;
    localparam int HSWT_TAP_FW = 0;
    localparam int HSWT_TAP_4K = 3;
    localparam int HSWT_TAP_2K = 4;

    // Mode register layout
    localparam int HSWT_MB_FAST = 1;
    localparam int HSWT_MB_RUN = 2;
    localparam int HSWT_MB_SEL_LO = 4;
    localparam int HSWT_MB_TONE = 7;
    localparam logic [7:0] HSWT_MODE_RST = 8'h00;
    localparam logic [7:0] HSWT_MODE_RMASK = 8'hB6;

    // Tone selections
    localparam logic [1:0] HSWT_SEL_2K = 2'h0;
    localparam logic [1:0] HSWT_SEL_4K = 2'h1;
    localparam logic [1:0] HSWT_SEL_FW = 2'h2;

    typedef struct packed {
        logic tone_en;
        logic [1:0] tone_sel;
        logic run;
        logic fast;
    } hswt_mode_s;

    typedef struct packed {
        logic level;
        logic oe;
    } hswt_pin_s;
endpackage

/* src/hswt_watch_timer.sv */
/*
 * Half-second watch timer: base clock divider, tick flag, standby wake,
 * fast-feed mode, divider clear and tone output on a shared port pin.
 * Assumes mode writes, flag clears and port settings come from logic on
 * mclk_in, so none of them is synchronised.
 */
`timescale 1ns/1ps
module hswt_watch_timer #(
    parameter int CNT_W = hswt_pkg::HSWT_CNT_W
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Mode register access
    input wire logic mode_wr_in,
    input wire logic [7:0] mode_wdata_in,
    output logic [7:0] mode_rdata_out,
    // Divider clear and flag clear strobes
    input wire logic div_clear_in,
    input wire logic flag_clear_in,
    // Standby
    input wire logic standby_in,
    output logic watch_tick_flag_out,
    output logic standby_wake_out,
    // Shared port pin
    input wire logic port_out_mode_in,
    input wire logic port_latch_in,
    output logic port2_bit3_pin_out,
    output logic port2_bit3_pin_oe_out
);
    import hswt_pkg::*;

    logic half_en;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    hswt_mode_s mode_q;
    logic flag_q;
    logic wake_q;
    hswt_pin_s pin_q;
    logic tick_norm;
    logic tick_fast;
    logic watch_tick_source;
    logic tone_wave;
    logic tone_on_pin;

    function automatic logic low_ones(input logic [CNT_W-1:0] v,
                                      input int n);
        logic r;
        r = 1'b1;
        for (int i = 0; i < CNT_W; i++) begin
            if (i < n && !v[i]) begin
                r = 1'b0;
            end
        end
        return r;
    endfunction

    // Half-ticks at twice the base clock, from the 40 MHz core clock
    hswt_nco u_nco (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .clear_in(div_clear_in),
        .pulse_out(half_en)
    );

    // Tick when the counted span wraps; fast feed taps 128x lower
    assign tick_norm = half_en && mode_q.run &&
        low_ones(cnt_q, HSWT_TICK_BITS_NORM);
    assign tick_fast = half_en && mode_q.run &&
        low_ones(cnt_q, HSWT_TICK_BITS_FAST);
    assign watch_tick_source = mode_q.fast ? tick_fast : tick_norm;
    assign cnt_d = mode_q.run && half_en ? cnt_q + 1'b1 : cnt_q;

    // Tone selection; unused code falls back to the base clock
    assign tone_wave = (mode_q.tone_sel == HSWT_SEL_2K) ? cnt_q[HSWT_TAP_2K] :
                       (mode_q.tone_sel == HSWT_SEL_4K) ? cnt_q[HSWT_TAP_4K] :
                       cnt_q[HSWT_TAP_FW];
    assign tone_on_pin = port_out_mode_in && mode_q.tone_en;

    // Divider chain; clear keeps the run bit so timing restarts at once
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in || div_clear_in) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Mode register; bit zero is dropped since software keeps it zero
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            mode_q <= '0;
        end else if (mode_wr_in) begin
            mode_q.tone_en <= mode_wdata_in[HSWT_MB_TONE];
            mode_q.tone_sel <= mode_wdata_in[HSWT_MB_SEL_LO +: 2];
            mode_q.run <= mode_wdata_in[HSWT_MB_RUN];
            mode_q.fast <= mode_wdata_in[HSWT_MB_FAST];
        end
    end

    // Readback: bit three is undefined, driven zero here
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            mode_rdata_out <= HSWT_MODE_RST;
        end else begin
            mode_rdata_out <= {mode_q.tone_en, 1'b0, mode_q.tone_sel,
                1'b0, mode_q.run, mode_q.fast, 1'b0} & HSWT_MODE_RMASK;
        end
    end

    // Sticky flag; a tick in the clear cycle wins so no tick is lost
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            flag_q <= 1'b0;
        end else if (watch_tick_source) begin
            flag_q <= 1'b1;
        end else if (flag_clear_in) begin
            flag_q <= 1'b0;
        end
    end

    // Wake is a level held while standby and flag both stand
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= standby_in && (flag_q || watch_tick_source);
        end
    end

    // Pin mux registered; one cycle latency avoids glitches on switching
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            pin_q <= '0;
        end else begin
            pin_q.oe <= port_out_mode_in;
            pin_q.level <= tone_on_pin ? tone_wave : port_latch_in;
        end
    end

    assign watch_tick_flag_out = flag_q;
    assign standby_wake_out = wake_q;
    assign port2_bit3_pin_out = pin_q.level;
    assign port2_bit3_pin_oe_out = pin_q.oe;

    property p_norm_span;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (watch_tick_source && !mode_q.fast) |-> cnt_q[14:0] == 15'h7FFF;
    endproperty
    a_norm_span: assert property (p_norm_span)
        else $error("normal tick at wrong divider phase");

    property p_fast_span;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (watch_tick_source && mode_q.fast) |-> cnt_q[7:0] == 8'hFF;
    endproperty
    a_fast_span: assert property (p_fast_span)
        else $error("fast tick at wrong divider phase");

    property p_tick_sets;
        @(posedge mclk_in) disable iff (sys_rst_in)
        watch_tick_source |=> watch_tick_flag_out;
    endproperty
    a_tick_sets: assert property (p_tick_sets)
        else $error("tick did not set flag");

    property p_flag_holds;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (watch_tick_flag_out && !flag_clear_in) |=> watch_tick_flag_out;
    endproperty
    a_flag_holds: assert property (p_flag_holds)
        else $error("flag dropped without clear");

    property p_wake;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (watch_tick_source && standby_in) |=> standby_wake_out;
    endproperty
    a_wake: assert property (p_wake)
        else $error("standby not released by tick");

    property p_clear;
        @(posedge mclk_in) disable iff (sys_rst_in)
        div_clear_in |=> (cnt_q == '0) && !half_en;
    endproperty
    a_clear: assert property (p_clear)
        else $error("divider not cleared");

    property p_rd_bits;
        @(posedge mclk_in) disable iff (sys_rst_in)
        mode_wr_in |=> ##1 mode_rdata_out == (mode_wdata_in & 8'hB6) ||
            $past(mode_wr_in);
    endproperty
    a_rd_bits: assert property (p_rd_bits)
        else $error("mode readback wrong");

    property p_port_fn;
        @(posedge mclk_in) disable iff (sys_rst_in)
        !tone_on_pin |=> port2_bit3_pin_out == $past(port_latch_in);
    endproperty
    a_port_fn: assert property (p_port_fn)
        else $error("pin lost port function");

    property p_tone_fw;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (tone_on_pin && mode_q.tone_sel == HSWT_SEL_FW) |=>
            port2_bit3_pin_out == $past(cnt_q[0]);
    endproperty
    a_tone_fw: assert property (p_tone_fw)
        else $error("base tone not on pin");

    c_norm_tick: cover property (@(posedge mclk_in)
        watch_tick_source && !mode_q.fast);
    c_fast_tick: cover property (@(posedge mclk_in)
        watch_tick_source && mode_q.fast);
    c_wake: cover property (@(posedge mclk_in) $rose(standby_wake_out));
    c_set_clear: cover property (@(posedge mclk_in)
        watch_tick_source && flag_clear_in);
endmodule
